/* smrb_pkg.sv */
// smrb_pkg: register map, field positions and reset values of the measurement register bank
// assumes the serial slave and register file both sit on one system clock
package smrb_pkg;
   localparam logic [4:0] ADDR_CUR_HI = 5'h00;
   localparam logic [4:0] ADDR_CUR_LO = 5'h01;
   localparam logic [4:0] ADDR_VOLT_HI = 5'h02;
   localparam logic [4:0] ADDR_VOLT_LO = 5'h03;
   localparam logic [4:0] ADDR_STATUS = 5'h04;
   localparam logic [4:0] ADDR_DEC_CFG = 5'h05;
   localparam logic [4:0] ADDR_OUT_CFG = 5'h06;
   localparam logic [4:0] ADDR_FILT_CFG = 5'h07;
   localparam logic [4:0] ADDR_CLK_CFG = 5'h08;
   localparam logic [4:0] ADDR_RST_CTL = 5'h09;
   localparam logic [4:0] ADDR_MODE_CTL = 5'h0a;
   localparam logic [7:0] RST_DEC_CFG = 8'h45;
   localparam logic [7:0] RST_OUT_CFG = 8'hc5;
   localparam logic [7:0] RST_FILT_CFG = 8'h04;
   localparam logic [7:0] RST_CLK_CFG = 8'h20;
   localparam logic [7:0] RST_RST_CTL = 8'hc0;
   localparam logic [7:0] RST_MODE_CTL = 8'h00;
   // writable bit masks; reserved bits stay zero
   localparam logic [7:0] MASK_DEC_CFG = 8'hff;
   localparam logic [7:0] MASK_OUT_CFG = 8'hff;
   localparam logic [7:0] MASK_FILT_CFG = 8'hfe;
   localparam logic [7:0] MASK_CLK_CFG = 8'hfe;
   localparam logic [7:0] MASK_RST_CTL = 8'hc0;
   localparam logic [7:0] MASK_MODE_CTL = 8'hfc;
   localparam logic [7:0] STATUS_MASK = 8'hfe;
   localparam int BIT_CMD = 7;
   localparam int BIT_SOFT_ALL = 7;
   localparam int BIT_SOFT_PATH = 6;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // decoded configuration handed to the measurement path
   typedef struct packed {
      logic dsr_128;
      logic [1:0] chop_div;
      logic [3:0] second_comb_stage_log2;
      logic first_comb_stage_sat_mask;
      logic cur_en;
      logic volt_en;
      logic int_active_low;
      logic cur_rdy_mask;
      logic [1:0] src_normal;
      logic [1:0] src_standby;
      logic use_moving_avg;
      logic [3:0] avg_len;
      logic [1:0] path_arch;
      logic [1:0] osc_src;
      logic [1:0] osc_div;
      logic [1:0] clkout_div;
      logic slow_half;
      logic [1:0] op_mode;
      logic [2:0] discard_cycles;
      logic chop_pin_en;
   } smrb_cfg_t;

   typedef enum logic [1:0] {
      SMRB_IDLE = 2'b00,
      SMRB_HEAD = 2'b01,
      SMRB_WDATA = 2'b10,
      SMRB_RDATA = 2'b11
   } smrb_state_t;
endpackage

/* smrb_spi_master.sv */
// smrb_spi_master: behavioural serial master in place of the microcontroller
// assumes its tasks are called just after a rising edge of i_clk
`timescale 1ns/1ps
`default_nettype none
module smrb_spi_master
(
   input wire logic i_clk, // system clock, times each half period
   input wire logic i_miso, // data from the device
   output logic o_cs_n, // select, low active
   output logic o_sclk, // serial clock
   output logic o_mosi // serial data out
);
   logic cpol; // idle clock level of this frame
   initial
   begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
      cpol = 1'b0;
   end
   // six cycles per half period, twice the device minimum
   task automatic tick();
      repeat (6) @(posedge i_clk);
   endtask
   // park the clock first so the level is settled at select fall
   task automatic start(input logic pol);
      cpol = pol;
      o_sclk <= pol;
      tick();
      o_cs_n <= 1'b0;
      tick();
   endtask
   // msb first: change on the transfer edge, sample on the next one
   task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int b = 7; b >= 0; b--)
      begin
         o_sclk <= ~cpol;
         o_mosi <= tx[b];
         tick();
         o_sclk <= cpol;
         rx[b] = i_miso;
         tick();
      end
   endtask
   // deselect; data line stops showing the last bit
   task automatic stop();
      o_cs_n <= 1'b1;
      o_mosi <= ~o_mosi;
      tick();
   endtask
endmodule
`default_nettype wire

/* smrb_spi_regbank.sv */
// smrb_spi_regbank: four-wire serial slave and control/status register bank
// assumes serial pins are synchronous to i_clk and sclk is far slower than i_clk
`timescale 1ns/1ps
`default_nettype none

module smrb_spi_regbank
   import smrb_pkg::*;
(
   input wire logic i_clk, // 25 MHz system clock
   input wire logic i_rst, // async reset, active high
   input wire logic i_cs_n, // serial chip select, active low
   input wire logic i_sclk, // serial clock
   input wire logic i_mosi, // serial data in
   input wire logic [15:0] i_cur_result, // current channel result
   input wire logic [15:0] i_volt_result, // voltage channel result
   input wire logic [7:0] i_status, // event status from the path
   input wire logic i_soft_all_done, // whole-device soft reset finished
   input wire logic i_soft_path_done, // path soft reset finished
   output logic o_miso, // serial data out
   output logic o_miso_oe, // data out drive enable
   output smrb_cfg_t o_cfg, // decoded configuration
   output logic o_soft_all_req, // whole-device soft reset pending
   output logic o_soft_path_req // path soft reset pending
);
   // register storage
   logic [7:0] dec_cfg, next_dec_cfg; // current decimation
   logic [7:0] out_cfg, next_out_cfg; // current output
   logic [7:0] filt_cfg, next_filt_cfg; // current filter
   logic [7:0] clk_cfg, next_clk_cfg; // clock selection
   logic [7:0] rst_ctl, next_rst_ctl; // soft reset control
   logic [7:0] mode_ctl, next_mode_ctl; // operating mode
   // serial engine state
   smrb_state_t state, next_state; // frame phase
   logic sclk_d, next_sclk_d; // previous clock level
   logic cpol, next_cpol; // clock level at select fall
   logic cs_d, next_cs_d; // previous select level
   logic [2:0] bitcnt, next_bitcnt; // bit within byte
   logic [7:0] shreg, next_shreg; // receive shifter
   logic [7:0] txreg, next_txreg; // transmit shifter
   logic [4:0] addr, next_addr; // current address
   logic miso, next_miso; // output bit flop
   logic miso_oe, next_miso_oe; // output enable flop
   logic first_out, next_first_out; // first read bit pending
   smrb_cfg_t cfg, next_cfg; // registered config output
   logic all_req; // device reset request flop
   logic path_req; // path reset request flop

   // edge classification
   logic sclk_rise, sclk_fall, xfer_edge, samp_edge, cs_fall;
   logic [7:0] rx_byte;

   // read decode, used for the first and each following byte
   // results and status are taken live, so a byte reflects the
   // path at the moment its load edge is seen, not at frame start
   function automatic logic [7:0] rd_mux
   (
      input logic [4:0] a, // register address
      input logic [15:0] ic, // current result
      input logic [15:0] iv, // voltage result
      input logic [7:0] st, // raw event status
      input logic [7:0] r5, // decimation register
      input logic [7:0] r6, // output register
      input logic [7:0] r7, // filter register
      input logic [7:0] r8, // clock register
      input logic [7:0] r9, // soft reset register
      input logic [7:0] ra // mode register
   );
      logic [7:0] v;
      v = 8'h00; // unmapped reads zero
      unique case (a)
         ADDR_CUR_HI: v = ic[15:8];
         ADDR_CUR_LO: v = ic[7:0];
         ADDR_VOLT_HI: v = iv[15:8];
         ADDR_VOLT_LO: v = iv[7:0];
         ADDR_STATUS: v = st & STATUS_MASK;
         ADDR_DEC_CFG: v = r5;
         ADDR_OUT_CFG: v = r6;
         ADDR_FILT_CFG: v = r7;
         ADDR_CLK_CFG: v = r8;
         ADDR_RST_CTL: v = r9;
         ADDR_MODE_CTL: v = ra;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // edge detection; sample edge is falling when clock idled low
   // the pins are oversampled by i_clk, so an edge is seen one cycle
   // after the pin moves; each serial half period must span at least
   // three system clocks so read data is settled before the sample edge
   // limitation: no glitch filter, a runt pulse on the clock pin
   // counts as two edges and shifts the frame by one bit
   assign sclk_rise = i_sclk & ~sclk_d;
   assign sclk_fall = ~i_sclk & sclk_d;
   assign cs_fall = ~i_cs_n & cs_d;
   assign xfer_edge = cpol ? sclk_fall : sclk_rise;
   assign samp_edge = cpol ? sclk_rise : sclk_fall;
   assign rx_byte = {shreg[6:0], i_mosi};

   // frame timing, as seen from the system clock:
   // select fall: clock level latched as polarity, header begins
   // header: eight sample edges collect command, two spare bits
   // and the five address bits, most significant first
   // end of header, read: first data byte is fetched at once, so
   // its top bit can leave on the very next transfer edge
   // end of header, write: engine waits for data bytes
   // each further byte: address steps by one and wraps at five bits
   // write bytes land on their eighth sample edge; a frame cut
   // short leaves the partial byte unused and the registers intact
   // select high: output released one cycle later, engine idles
   // the soft reset done inputs are applied first and a write in the
   // same cycle overrides them, so a fresh request is never lost
   // trade-off: one next-state process for engine and registers
   // keeps write timing exact at the cost of a longer process
   //
   // output drive: the data out flop changes only in the cycle after
   // a transfer edge, so the master sees settled data for all but the
   // first system clock of the half period before its sample edge
   //
   // serial frame engine and register write path
   always_comb
   begin
      next_state = state;
      next_sclk_d = i_sclk;
      next_cs_d = i_cs_n;
      next_cpol = cpol;
      next_bitcnt = bitcnt;
      next_shreg = shreg;
      next_txreg = txreg;
      next_addr = addr;
      next_miso = miso;
      next_miso_oe = miso_oe;
      next_first_out = first_out;
      next_dec_cfg = dec_cfg;
      next_out_cfg = out_cfg;
      next_filt_cfg = filt_cfg;
      next_clk_cfg = clk_cfg;
      next_mode_ctl = mode_ctl;
      next_rst_ctl = rst_ctl;
      // soft reset bits return to one on completion
      if (i_soft_all_done)
      begin
         next_rst_ctl[BIT_SOFT_ALL] = 1'b1;
      end
      if (i_soft_path_done)
      begin
         next_rst_ctl[BIT_SOFT_PATH] = 1'b1;
      end
      if (i_cs_n)
      begin
         // deselected: release the output and drop the frame
         next_state = SMRB_IDLE;
         next_miso_oe = 1'b0;
      end
      else if (cs_fall)
      begin
         // polarity fixed for the frame by the clock level now
         next_cpol = i_sclk;
         next_state = SMRB_HEAD;
         next_bitcnt = 3'h0;
      end
      else if (state != SMRB_IDLE)
      begin
         // read data goes out on the transfer edge
         if (state == SMRB_RDATA && xfer_edge)
         begin
            next_miso_oe = 1'b1;
            if (first_out)
            begin
               next_miso = txreg[7];
               next_txreg = {txreg[6:0], 1'b0};
               next_first_out = 1'b0;
            end
            else
            begin
               next_miso = txreg[7];
               next_txreg = {txreg[6:0], 1'b0};
            end
         end
         // master bits are taken on the edge after the transfer edge
         if (samp_edge)
         begin
            next_shreg = rx_byte;
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == BIT_LAST)
            begin
               unique case (state)
                  SMRB_HEAD:
                  begin
                     next_addr = rx_byte[4:0];
                     if (rx_byte[BIT_CMD])
                     begin
                        next_state = SMRB_RDATA;
                        next_txreg = rd_mux(rx_byte[4:0], i_cur_result, i_volt_result,
                           i_status, dec_cfg, out_cfg, filt_cfg, clk_cfg, rst_ctl,
                           mode_ctl);
                        next_first_out = 1'b1;
                     end
                     else
                     begin
                        next_state = SMRB_WDATA;
                     end
                  end
                  SMRB_WDATA:
                  begin
                     // read-only and unmapped addresses ignore data
                     unique case (addr)
                        ADDR_DEC_CFG: next_dec_cfg = rx_byte & MASK_DEC_CFG;
                        ADDR_OUT_CFG: next_out_cfg = rx_byte & MASK_OUT_CFG;
                        ADDR_FILT_CFG: next_filt_cfg = rx_byte & MASK_FILT_CFG;
                        ADDR_CLK_CFG: next_clk_cfg = rx_byte & MASK_CLK_CFG;
                        ADDR_RST_CTL: next_rst_ctl = rx_byte & MASK_RST_CTL;
                        ADDR_MODE_CTL: next_mode_ctl = rx_byte & MASK_MODE_CTL;
                        default: next_addr = addr;
                     endcase
                     next_addr = addr + 5'h01;
                  end
                  SMRB_RDATA:
                  begin
                     // master keeps clocking for more bytes
                     next_addr = addr + 5'h01;
                     next_txreg = rd_mux(addr + 5'h01, i_cur_result, i_volt_result,
                        i_status, dec_cfg, out_cfg, filt_cfg, clk_cfg, rst_ctl,
                        mode_ctl);
                     next_first_out = 1'b1;
                  end
                  default: next_state = SMRB_IDLE;
               endcase
            end
         end
      end
   end

   // field decode into the config bundle
   // pure bit slicing; the bundle is registered below so every
   // output leaves the block from a flop, one cycle behind the bank
   // reserved bits are masked at write time, never here
   always_comb
   begin
      next_cfg.dsr_128 = dec_cfg[7];
      next_cfg.chop_div = dec_cfg[6:5];
      next_cfg.second_comb_stage_log2 = dec_cfg[4:1];
      next_cfg.first_comb_stage_sat_mask = dec_cfg[0];
      next_cfg.cur_en = out_cfg[7];
      next_cfg.volt_en = out_cfg[6];
      next_cfg.int_active_low = out_cfg[5];
      next_cfg.cur_rdy_mask = out_cfg[4];
      next_cfg.src_normal = out_cfg[3:2];
      next_cfg.src_standby = out_cfg[1:0];
      next_cfg.use_moving_avg = filt_cfg[7];
      next_cfg.avg_len = filt_cfg[6:3];
      next_cfg.path_arch = filt_cfg[2:1];
      next_cfg.osc_src = clk_cfg[7:6];
      next_cfg.osc_div = clk_cfg[5:4];
      next_cfg.clkout_div = clk_cfg[3:2];
      next_cfg.slow_half = clk_cfg[1];
      next_cfg.op_mode = mode_ctl[7:6];
      next_cfg.discard_cycles = mode_ctl[5:3];
      next_cfg.chop_pin_en = mode_ctl[2];
   end

   // state registers; all take constants under reset
   // the bundle clears to zero during reset rather than showing the
   // register defaults, so the path sees no half-valid setup while
   // reset is still applied
   // request flops follow the next register value, so they move in
   // the same cycle as the stored reset bits
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state <= SMRB_IDLE;
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
         cpol <= 1'b0;
         bitcnt <= 3'h0;
         shreg <= 8'h00;
         txreg <= 8'h00;
         addr <= 5'h00;
         miso <= 1'b0;
         miso_oe <= 1'b0;
         first_out <= 1'b0;
         dec_cfg <= RST_DEC_CFG;
         out_cfg <= RST_OUT_CFG;
         filt_cfg <= RST_FILT_CFG;
         clk_cfg <= RST_CLK_CFG;
         rst_ctl <= RST_RST_CTL;
         mode_ctl <= RST_MODE_CTL;
         cfg <= '0;
         all_req <= 1'b0; // reset bits default to one
         path_req <= 1'b0;
      end
      else
      begin
         state <= next_state;
         sclk_d <= next_sclk_d;
         cs_d <= next_cs_d;
         cpol <= next_cpol;
         bitcnt <= next_bitcnt;
         shreg <= next_shreg;
         txreg <= next_txreg;
         addr <= next_addr;
         miso <= next_miso;
         miso_oe <= next_miso_oe;
         first_out <= next_first_out;
         dec_cfg <= next_dec_cfg;
         out_cfg <= next_out_cfg;
         filt_cfg <= next_filt_cfg;
         clk_cfg <= next_clk_cfg;
         rst_ctl <= next_rst_ctl;
         mode_ctl <= next_mode_ctl;
         cfg <= next_cfg;
         all_req <= ~next_rst_ctl[BIT_SOFT_ALL];
         path_req <= ~next_rst_ctl[BIT_SOFT_PATH];
      end
   end

   // soft reset requests: inverted stored bits, held in own flops
   // a request stays up until the matching done input returns or a write sets the bit back to one
   assign o_soft_all_req = all_req;
   assign o_soft_path_req = path_req;

   // serial and config outputs straight from their flops
   assign o_miso = miso;
   assign o_miso_oe = miso_oe;
   assign o_cfg = cfg;
endmodule

`default_nettype wire

/* smrb_spi_regbank_checker.sv */
// checker: port-level assertions of the serial register bank
// assumes it is bound onto smrb_spi_regbank; serial clock far slower than i_clk
`timescale 1ns/1ps
`default_nettype none
module smrb_spi_regbank_checker
   import smrb_pkg::*;
(
   input wire logic i_clk, // system clock
   input wire logic i_rst, // async reset
   input wire logic i_cs_n, // select, low active
   input wire logic i_sclk, // serial clock
   input wire logic i_soft_all_done, // device reset done
   input wire logic i_soft_path_done, // path reset done
   input wire logic o_miso, // serial out
   input wire logic o_miso_oe, // serial out enable
   input wire smrb_cfg_t o_cfg, // decoded fields
   input wire logic o_soft_all_req, // device reset pending
   input wire logic o_soft_path_req // path reset pending
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic sclk_q; // last serial clock level
   logic [3:0] quiet; // cycles since the serial clock moved
   logic [3:0] next_quiet;
   // saturating, so long idle gaps never wrap to zero
   always_comb next_quiet = (i_sclk != sclk_q) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sclk_q <= 1'b0;
         quiet <= 4'h0;
      end
      else
      begin
         sclk_q <= i_sclk;
         quiet <= next_quiet;
      end
   end
   // two deselected cycles in a row
   sequence s_idle2;
      i_cs_n ##1 i_cs_n;
   endsequence
   a_oe_idle: assert property (s_idle2 |-> !o_miso_oe)
      else $error("miso driven while deselected");
   a_oe_frame: assert property ($rose(o_miso_oe) |-> !i_cs_n)
      else $error("miso enable rose outside a frame");
   a_miso_hold: assert property (o_miso_oe && !i_cs_n && quiet >= 4'h4 |-> $stable(o_miso))
      else $error("miso moved between transfer edges");
   a_cfg_reset: assert property (!i_rst && $past(i_rst) |-> ##[1:2] (!o_cfg.dsr_128 &&
      o_cfg.chop_div == 2'b10 && o_cfg.second_comb_stage_log2 == 4'h2 && o_cfg.first_comb_stage_sat_mask && o_cfg.cur_en &&
      o_cfg.src_standby == 2'b01 && o_cfg.path_arch == 2'b10 && o_cfg.osc_div == 2'b10))
      else $error("configuration not at reset values");
   a_all_done: assert property (o_soft_all_req && i_soft_all_done && i_cs_n
      |-> ##[1:2] !o_soft_all_req)
      else $error("device reset request not cleared");
   a_path_done: assert property (o_soft_path_req && i_soft_path_done && i_cs_n
      |-> ##[1:2] !o_soft_path_req)
      else $error("path reset request not cleared");
   a_all_start: assert property ($rose(o_soft_all_req) |-> !$past(i_cs_n))
      else $error("device reset request outside a write");
   a_path_start: assert property ($rose(o_soft_path_req) |-> !$past(i_cs_n))
      else $error("path reset request outside a write");
endmodule
bind smrb_spi_regbank smrb_spi_regbank_checker u_chk (.*);
`default_nettype wire

/* test_spi_measurement_register_bank.sv */
// test_spi_measurement_register_bank: self-checking bench with a register model
// assumes the master model and the bound checker compile beside the design
`timescale 1ns/1ps
`default_nettype none
module test_spi_measurement_register_bank
   import smrb_pkg::*;
;
   logic clk = 1'b0; // 25 MHz system clock
   logic rst = 1'b1; // async reset
   logic [15:0] cur = 16'h0000; // current result
   logic [15:0] volt = 16'h0000; // voltage result
   logic [7:0] stat = 8'h00; // event status
   logic all_done = 1'b0; // device reset finished
   logic path_done = 1'b0; // path reset finished
   logic cs_n, sclk, mosi, miso, miso_oe, miso_w, all_req, path_req;
   smrb_cfg_t cfg; // decoded configuration
   int seed = 87;
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   logic [7:0] r [0:31]; // model register file
   logic [7:0] wm [0:31]; // writable bits per address
   always #20 clk = ~clk;
   // released line shows the inverse, never a held value
   assign miso_w = miso_oe ? miso : ~miso;
   smrb_spi_master m (.i_clk(clk), .i_miso(miso_w), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
   smrb_spi_regbank dut (.i_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_mosi(mosi),
      .i_cur_result(cur), .i_volt_result(volt), .i_status(stat), .i_soft_all_done(all_done),
      .i_soft_path_done(path_done), .o_miso(miso), .o_miso_oe(miso_oe), .o_cfg(cfg),
      .o_soft_all_req(all_req), .o_soft_path_req(path_req));
   // expected read byte at an address
   function automatic logic [7:0] rd_exp(input logic [4:0] a);
      case (a)
         5'h00: return cur[15:8];
         5'h01: return cur[7:0];
         5'h02: return volt[15:8];
         5'h03: return volt[7:0];
         5'h04: return stat & 8'hfe; // bit 0 reads zero
         default: return r[a]; // unmapped stay zero
      endcase
   endfunction
   task automatic chk(input logic [35:0] seen, input logic [35:0] want);
      checks++;
      if (seen !== want)
      begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // one frame; dv below zero sends random bytes, else that byte each time
   task automatic frame(input logic pol, input logic rd, input logic [4:0] a, input int n,
      input int dv);
      logic [7:0] tx, rx;
      logic [4:0] p;
      p = a;
      m.start(pol);
      m.xbyte({rd, 2'b00, a}, rx);
      repeat (n)
      begin
         tx = (dv < 0) ? 8'($random(seed)) : dv[7:0];
         m.xbyte(tx, rx);
         if (rd)
            chk(36'(rx), 36'(rd_exp(p)));
         else
            r[p] = tx & wm[p];
         p = p + 5'h01; // wraps after the top address
      end
      m.stop();
      chk(36'(cfg), {r[5], r[6], r[7][7:1], r[8][7:1], r[10][7:2]});
      chk(36'({all_req, path_req}), 36'({~r[9][7], ~r[9][6]}));
   endtask
   // hang guard, well above the planned run
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         failures++;
         tally_and_finish();
      end
   end
   initial
   begin
      logic [4:0] a;
      wm = '{5: MASK_DEC_CFG, 6: MASK_OUT_CFG, 7: MASK_FILT_CFG, 8: MASK_CLK_CFG,
         9: MASK_RST_CTL, 10: MASK_MODE_CTL, default: 8'h00};
      r = '{5: 8'h45, 6: 8'hc5, 7: 8'h04, 8: 8'h20, 9: 8'hc0, default: 8'h00};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      cur <= 16'ha5c3;
      volt <= 16'h3c5a;
      stat <= 8'hff;
      @(posedge clk);
      frame(1'b0, 1'b1, 5'h00, 16, 0);
      frame(1'b1, 1'b1, 5'h1e, 4, 0);
      // each field pattern across a six-byte burst
      for (int c = 0; c < 16; c++)
         frame(c[0], 1'b0, 5'h05, 6, {c[3:0], c[3:0]});
      frame(1'b0, 1'b0, 5'h09, 1, 0);
      all_done <= 1'b1;
      path_done <= 1'b1;
      @(posedge clk);
      all_done <= 1'b0;
      path_done <= 1'b0;
      r[9] = 8'hc0;
      repeat (3) @(posedge clk);
      chk(36'({all_req, path_req}), 36'h0);
      for (int k = 0; k < 20; k++)
      begin
         cur <= 16'($random(seed));
         volt <= 16'($random(seed));
         stat <= 8'($random(seed));
         a = 5'($random(seed)) & 5'h0f;
         frame(k[0], 1'b0, a, 1 + k % 3, -1);
         frame(k[1], 1'b1, a, 1 + k % 3, -1);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
